/* File: design/fppc_top.sv */
// flash program/protect controller: APB register slave, protection checks, read recovery
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module fppc_top #(
	parameter int ADDR_W = 16,
	parameter int BPR_W  = 8
) (
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// test high voltage detect pin
	input  wire logic        test_high_voltage,
	// flash array controls
	output logic             program_enable_bit,
	output logic             erase_enable_bit,
	output logic             mass_erase_bit,
	output logic             high_voltage_enable_bit,
	output logic             array_read_ready,
	output logic             monitor_mode_select
);

	if (ADDR_W != 16 || BPR_W != 8) begin : g_param_check
		$error("fppc_top: only a 16-bit space with an 8-bit protect value is supported");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] region_start(input logic [7:0] bpr);
		region_start = {bpr, 8'h00};
	endfunction

	function automatic logic is_protected(input logic [7:0] bpr, input logic [15:0] addr);
		// all ones means nothing is locked; anything else locks start..top
		is_protected = (bpr != fppc_pkg::PROTECT_ALL_OPEN) && (addr >= region_start(bpr));
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	fppc_pkg::fppc_ctrl_t ctrl_reg, ctrl_next;
	logic [7:0]  protect_reg, protect_next;
	logic [15:0] target_reg, target_next;
	logic        refused_reg, refused_next;
	logic [4:0]  rcv_cnt_reg, rcv_cnt_next;
	logic        ready_reg, ready_next;
	logic        tst_meta_reg, tst_sync_reg;
	logic [1:0]  cap_cnt_reg, cap_cnt_next;
	logic        monitor_reg, monitor_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next;

	logic        wr_fire;
	logic        rd_fire;
	logic        hv_deny;
	logic        mapped;
	fppc_pkg::fppc_ctrl_t wr_ctrl;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_next    = ctrl_reg;
		protect_next = protect_reg;
		target_next  = target_reg;
		refused_next = refused_reg;
		rcv_cnt_next = rcv_cnt_reg;
		ready_next   = ready_reg;
		cap_cnt_next = cap_cnt_reg;
		monitor_next = monitor_reg;
		prdata_next  = prdata_reg;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		wr_ctrl      = fppc_pkg::fppc_ctrl_t'(pwdata[3:0]);
		hv_deny      = 1'b0;

		mapped = 1'b0;
		if (paddr == fppc_pkg::CTRL_OFS) begin
			mapped = 1'b1;
		end else if (paddr == fppc_pkg::PROTECT_OFS) begin
			mapped = 1'b1;
		end else if (paddr == fppc_pkg::TARGET_OFS) begin
			mapped = 1'b1;
		end else if (paddr == fppc_pkg::STATUS_OFS) begin
			mapped = 1'b1;
		end

		// one wait state so every answer leaves a flip-flop
		rd_fire = psel && penable && !pready_reg;
		wr_fire = psel && penable && pready_reg && pwrite;
		if (rd_fire) begin
			pready_next  = 1'b1;
			pslverr_next = !mapped;
			prdata_next  = 32'h0000_0000;
			if (paddr == fppc_pkg::CTRL_OFS) begin
				prdata_next[3:0] = ctrl_reg;
			end else if (paddr == fppc_pkg::PROTECT_OFS) begin
				prdata_next[7:0] = protect_reg;
			end else if (paddr == fppc_pkg::TARGET_OFS) begin
				prdata_next[15:0] = target_reg;
			end else if (paddr == fppc_pkg::STATUS_OFS) begin
				prdata_next[fppc_pkg::STAT_READY_BIT]   = ready_reg;
				prdata_next[fppc_pkg::STAT_REFUSED_BIT] = refused_reg;
				prdata_next[fppc_pkg::STAT_TST_BIT]     = tst_sync_reg;
				prdata_next[fppc_pkg::STAT_MONITOR_BIT] = monitor_reg;
			end
		end

		// protection check on the value being written
		if (wr_ctrl.hv && !ctrl_reg.hv) begin
			if (wr_ctrl.erase && wr_ctrl.mass && protect_reg != fppc_pkg::PROTECT_ALL_OPEN)
				hv_deny = 1'b1;
			else if ((wr_ctrl.prog || wr_ctrl.erase) && is_protected(protect_reg, target_reg))
				hv_deny = 1'b1;
		end

		if (wr_fire) begin
			if (paddr == fppc_pkg::CTRL_OFS) begin
				ctrl_next = wr_ctrl;
				if (hv_deny) begin
					ctrl_next.hv   = 1'b0;
					refused_next   = 1'b1;
				end
			end else if (paddr == fppc_pkg::PROTECT_OFS) begin
				// locked value moves only with the test voltage present
				if (tst_sync_reg)
					protect_next = pwdata[7:0];
				else
					refused_next = 1'b1;
			end else if (paddr == fppc_pkg::TARGET_OFS) begin
				target_next = pwdata[15:0];
			end else if (paddr == fppc_pkg::STATUS_OFS) begin
				// write one clears; a refusal in the same cycle wins
				if (pwdata[fppc_pkg::STAT_REFUSED_BIT])
					refused_next = 1'b0;
			end
		end
		if (wr_fire && hv_deny && paddr == fppc_pkg::CTRL_OFS)
			refused_next = 1'b1;
		if (wr_fire && !tst_sync_reg && paddr == fppc_pkg::PROTECT_OFS)
			refused_next = 1'b1;

		// read recovery after high voltage falls
		// reload on the clearing edge too, so the full count runs after hv falls
		if (ctrl_next.hv || ctrl_reg.hv) begin
			ready_next   = 1'b0;
			rcv_cnt_next = 5'(fppc_pkg::RCV_CYCLES);
		end else if (rcv_cnt_reg != 5'h00) begin
			rcv_cnt_next = rcv_cnt_reg - 5'h01;
			ready_next   = (rcv_cnt_reg == 5'h01);
		end

		// strap the test voltage once after reset release
		if (cap_cnt_reg != 2'(fppc_pkg::CAPTURE_DELAY)) begin
			cap_cnt_next = cap_cnt_reg + 2'h1;
			if (cap_cnt_reg == 2'(fppc_pkg::CAPTURE_DELAY - 1))
				monitor_next = tst_sync_reg;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg     <= '0;
			protect_reg  <= fppc_pkg::PROTECT_RST;
			target_reg   <= fppc_pkg::TARGET_RST;
			refused_reg  <= 1'b0;
			rcv_cnt_reg  <= 5'h00;
			ready_reg    <= 1'b1;
			tst_meta_reg <= 1'b0;
			tst_sync_reg <= 1'b0;
			cap_cnt_reg  <= 2'h0;
			monitor_reg  <= 1'b0;
			prdata_reg   <= 32'h0000_0000;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
		end else if (clk_en) begin
			ctrl_reg     <= ctrl_next;
			protect_reg  <= protect_next;
			target_reg   <= target_next;
			refused_reg  <= refused_next;
			rcv_cnt_reg  <= rcv_cnt_next;
			ready_reg    <= ready_next;
			tst_meta_reg <= test_high_voltage;
			tst_sync_reg <= tst_meta_reg;
			cap_cnt_reg  <= cap_cnt_next;
			monitor_reg  <= monitor_next;
			prdata_reg   <= prdata_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
		end
	end

	assign prdata                  = prdata_reg;
	assign pready                  = pready_reg;
	assign pslverr                 = pslverr_reg;
	assign program_enable_bit      = ctrl_reg.prog;
	assign erase_enable_bit        = ctrl_reg.erase;
	assign mass_erase_bit          = ctrl_reg.mass;
	assign high_voltage_enable_bit = ctrl_reg.hv;
	assign array_read_ready        = ready_reg;
	assign monitor_mode_select     = monitor_reg;

endmodule

/* File: design/fppc_pkg.sv */
// package: register map, field layout and timing for the flash program/protect controller
package fppc_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] PROTECT_OFS = 8'h04;
	localparam logic [7:0] TARGET_OFS  = 8'h08;
	localparam logic [7:0] STATUS_OFS  = 8'h0C;
	// control fields
	localparam int CTRL_PROG_BIT  = 0;
	localparam int CTRL_ERASE_BIT = 1;
	localparam int CTRL_MASS_BIT  = 2;
	localparam int CTRL_HV_BIT    = 3;
	// status fields
	localparam int STAT_READY_BIT   = 0;
	localparam int STAT_REFUSED_BIT = 1;
	localparam int STAT_TST_BIT     = 2;
	localparam int STAT_MONITOR_BIT = 3;
	// reset values and the all-open protect value
	localparam logic [7:0]  PROTECT_RST = 8'hFF;
	localparam logic [7:0]  PROTECT_ALL_OPEN = 8'hFF;
	localparam logic [15:0] TARGET_RST  = 16'h0000;
	// timing
	localparam int CLK_MHZ         = 20;
	localparam int PROG_TIME_NS    = 30000;
	localparam int NVH_TIME_NS     = 5000;
	localparam int RCV_TIME_NS     = 1000;
	localparam int RCV_CYCLES      = (RCV_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int CAPTURE_DELAY   = 3;

	typedef struct packed {
		logic hv;
		logic mass;
		logic erase;
		logic prog;
	} fppc_ctrl_t;
endpackage

/* File: sim/fppc_asserts.sv */
// checker: bus answer, control and recovery properties of the flash controller
`timescale 1ns/1ps
module fppc_asserts (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins and array controls
	input wire logic        test_high_voltage,
	input wire logic        program_enable_bit,
	input wire logic        erase_enable_bit,
	input wire logic        high_voltage_enable_bit,
	input wire logic        array_read_ready,
	input wire logic        monitor_mode_select
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr;
	logic hv_wr;
	assign wr    = psel && penable && pready && pwrite && clk_en;
	assign hv_wr = wr && paddr == 8'h00 && pwdata[3];
	AST_PULSE: assert property (pready |=> !pready) else $error("pready wider than one cycle");
	AST_WAIT: assert property (psel && penable && !pready && clk_en |=> pready) else $error("no answer");
	AST_ERR: assert property (psel && penable && !pready && clk_en && paddr > 8'h0C |=> pslverr)
		else $error("unmapped access not flagged");
	AST_CTRL: assert property (wr && paddr == 8'h00 |=> program_enable_bit == $past(pwdata[0])
		&& erase_enable_bit == $past(pwdata[1])) else $error("control bits not taken");
	AST_HVSRC: assert property ($rose(high_voltage_enable_bit) |-> $past(hv_wr)) else $error("hv rose alone");
	AST_HVREAD: assert property (high_voltage_enable_bit && $past(high_voltage_enable_bit) |-> !array_read_ready)
		else $error("array readable under hv");
	AST_RCV: assert property ($fell(high_voltage_enable_bit) |-> ##19 !array_read_ready ##1 array_read_ready)
		else $error("recovery time wrong");
	AST_MON: assert property ($rose(monitor_mode_select) |-> $past(test_high_voltage, 3))
		else $error("monitor without test voltage");
endmodule
bind fppc_top fppc_asserts fppc_asserts_inst (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .test_high_voltage, .program_enable_bit, .erase_enable_bit,
	.high_voltage_enable_bit, .array_read_ready, .monitor_mode_select);

/* File: sim/fppc_cpu_model.sv */
// partner: software issuing apb transfers and the program/erase sequence
`timescale 1ns/1ps
module fppc_cpu_model (
	// clock
	input wire logic        pclk,
	// apb request
	output logic            psel,
	output logic            penable,
	output logic            pwrite,
	output logic [7:0]      paddr,
	output logic [31:0]     pwdata,
	// apb answer
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// answer taken at the rising edge that sees pready high; request released only then
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// top word never written while hv may be set
	task automatic seq(input logic [15:0] t, input logic [3:0] w, output logic [31:0] rb);
		logic [31:0] q;
		logic e;
		xfer(1'b1, 8'h08, {16'h0, t}, q, e);
		xfer(1'b1, 8'h00, {29'h0, w[2:0]}, q, e);
		xfer(1'b0, 8'h04, 32'h0, q, e);
		xfer(1'b1, 8'h00, {28'h0, w}, q, e);
		xfer(1'b0, 8'h00, 32'h0, rb, e);
		repeat (600) @(posedge pclk);
		xfer(1'b1, 8'h00, {28'h0, rb[3], 3'h0}, q, e);
		repeat (100) @(posedge pclk);
		xfer(1'b1, 8'h00, 32'h0, q, e);
		repeat (25) @(posedge pclk);
	endtask
endmodule

/* File: sim/tb_flash_program_protect_ctrl.sv */
// testbench: protection table, lock, unmapped access and monitor strap
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
	$display("ERROR %0t: got %h expected %h", $time, a, b); end end
module tb_flash_program_protect_ctrl;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic test_high_voltage = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic program_enable_bit, erase_enable_bit, mass_erase_bit, high_voltage_enable_bit;
	logic array_read_ready, monitor_mode_select, e;
	int n_errors = 0;
	int checked = 0;
	// protect, target, control written, control expected back
	logic [31:0] tbl [7] = '{32'h80900091, 32'h807FFF99, 32'h808000A2, 32'h00000091,
		32'hFFFFFE99, 32'hFF0000EE, 32'hFE0000E6};
	initial forever #25 pclk = ~pclk;
	fppc_cpu_model fppc_cpu_model_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);
	fppc_top fppc_top_inst (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .test_high_voltage, .program_enable_bit, .erase_enable_bit,
		.mass_erase_bit, .high_voltage_enable_bit, .array_read_ready, .monitor_mode_select);
	task conclude;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		fppc_cpu_model_inst.xfer(1'b0, 8'h04, 32'h0, q, e);
		`CHK(q, 32'hFF)
		fppc_cpu_model_inst.xfer(1'b1, 8'h10, 32'h5, q, e);
		`CHK(e, 1'b1)
		test_high_voltage <= 1'b1;
		repeat (4) @(posedge pclk);
		for (int i = 0; i < 7; i++) begin
			fppc_cpu_model_inst.xfer(1'b1, 8'h04, {24'h0, tbl[i][31:24]}, q, e);
			fppc_cpu_model_inst.seq(tbl[i][23:8], tbl[i][7:4], q);
			`CHK(q[3:0], tbl[i][3:0])
		end
		`CHK(array_read_ready, 1'b1)
		fppc_cpu_model_inst.xfer(1'b1, 8'h0C, 32'h2, q, e);
		fppc_cpu_model_inst.xfer(1'b0, 8'h0C, 32'h0, q, e);
		`CHK(q, 32'h5)
		fppc_cpu_model_inst.xfer(1'b1, 8'h00, 32'h7, q, e);
		fppc_cpu_model_inst.xfer(1'b1, 8'h00, 32'hF, q, e);
		@(negedge pclk);
		`CHK({high_voltage_enable_bit, mass_erase_bit, erase_enable_bit, program_enable_bit}, 4'h7)
		fppc_cpu_model_inst.xfer(1'b0, 8'h0C, 32'h0, q, e);
		`CHK(q, 32'h7)
		fppc_cpu_model_inst.xfer(1'b1, 8'h00, 32'h1, q, e);
		fppc_cpu_model_inst.xfer(1'b0, 8'h04, 32'h0, q, e);
		fppc_cpu_model_inst.xfer(1'b1, 8'h00, 32'h9, q, e);
		@(negedge pclk);
		`CHK({high_voltage_enable_bit, array_read_ready}, 2'b10)
		fppc_cpu_model_inst.xfer(1'b1, 8'h00, 32'h8, q, e);
		repeat (100) @(posedge pclk);
		fppc_cpu_model_inst.xfer(1'b1, 8'h00, 32'h0, q, e);
		repeat (20) @(negedge pclk);
		`CHK(array_read_ready, 1'b0)
		@(negedge pclk);
		`CHK(array_read_ready, 1'b1)
		test_high_voltage <= 1'b0;
		repeat (4) @(posedge pclk);
		fppc_cpu_model_inst.xfer(1'b1, 8'h04, 32'h12, q, e);
		fppc_cpu_model_inst.xfer(1'b0, 8'h04, 32'h0, q, e);
		`CHK(q, 32'hFE)
		presetn <= 1'b0;
		test_high_voltage <= 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		`CHK(monitor_mode_select, 1'b1)
		conclude();
	end
endmodule
